/* src/ser_cfg.svh */
// Constants for the SMI enable and routing block.
// Assumes a single 250 MHz clock and a plain register port.
//
// What this block does
// - Enable bits active high; one passes.
// - En2 bits 0-2 gate mouse, keyboard, infrared.
// - En2 bit 3 reserved; bit 4 gates port line.
// - En2 bit 5 routes group SMI to wake.
// - En2 bit 6 routes group SMI to serirq.
// - En2 bit 7 drives group SMI to pin.
// - En3 bits 0-2 enable gpio 20-22.
// - En3 bit 3 reserved; bits 4-7 gpio 24-26,60.
// - En4 at 0x19 gates further sources.
// - All enables read/write, clear on reset.
`ifndef SER_CFG_SVH
`define SER_CFG_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define SER_OFS_EN2 8'h17
`define SER_OFS_EN3 8'h18
`define SER_OFS_EN4 8'h19
`define SER_OFS_IST 8'h1A
`define SER_OFS_IMSK 8'h1B
`define SER_RST_VAL 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SER_EN2_SRC_MASK 8'h17
`define SER_EN3_SRC_MASK 8'hF7
`define SER_BIT_WAKE 5
`define SER_BIT_SERIRQ 6
`define SER_BIT_PIN 7
`define SER_IST_RISE 0
`define SER_IST_FALL 1

`endif

/* src/ser_pkg.sv */
// Types for the SMI enable and routing block.
// Assumes ser_cfg.svh supplies the constants.
package ser_pkg;
  // Group SMI routes, all active high.
  typedef struct packed {
    logic to_wake;
    logic to_serirq;
    logic to_pin;
  } ser_route_t;
endpackage

/* src/ser_smi_route.sv */
// SMI source gating and group SMI routing with its enable registers.
// Assumes source inputs come from pins and are synchronised here.
`timescale 1ns/1ns
`include "ser_cfg.svh"

module ser_smi_route
  import ser_pkg::*;
#(
  parameter int EXTRA_W = 8
) (
  input wire logic i_clock, // 250 MHz clock
  input wire logic i_sys_rst, // Sync reset, active high
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [7:0] o_rdata, // Read data, cycle after strobe
  input wire logic [7:0] i_per_src, // Bits 0-2 mouse/kbd/ir, bit 4 port line
  input wire logic [7:0] i_gpio_src, // gpio 20,21,22,-,24,25,26,60
  input wire logic [EXTRA_W-1:0] i_extra_src, // Further sources
  output ser_route_t o_route, // Group SMI to wake and serirq; to_pin stays 0
  output logic o_smi_pin_n, // Dedicated pin level, active low
  output logic o_smi_pin_oe_n, // Pin enable, low while driving
  output logic o_group_smi_out_n, // Group SMI, active low
  output logic o_irq // Block interrupt, level
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int SW = 16 + EXTRA_W;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {i_extra_src, i_gpio_src, i_per_src};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // Enable registers
  // ----------------------------------------
  logic [7:0] en2_reg;
  logic [7:0] en3_reg;
  logic [EXTRA_W-1:0] en4_reg;
  logic [7:0] ist_reg;
  logic [7:0] imsk_reg;
  logic group_reg;
  logic group_next;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      en2_reg <= `SER_RST_VAL;
      en3_reg <= `SER_RST_VAL;
      en4_reg <= '0;
    end else if (i_wr) begin
      if (i_addr == `SER_OFS_EN2) begin
        en2_reg <= i_wdata;
      end
      if (i_addr == `SER_OFS_EN3) begin
        en3_reg <= i_wdata;
      end
      if (i_addr == `SER_OFS_EN4) begin
        en4_reg <= i_wdata[EXTRA_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Source gating
  // ----------------------------------------
  // Reserved bit 3 of the En2 and En3 source bytes is masked, so a stored one there is inert.
  always_comb begin
    group_next = |(sync2_reg[7:0] & en2_reg & `SER_EN2_SRC_MASK)
      | |(sync2_reg[15:8] & en3_reg & `SER_EN3_SRC_MASK)
      | |(sync2_reg[SW-1:16] & en4_reg);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      group_reg <= 1'b0;
    end else begin
      group_reg <= group_next;
    end
  end

  // ----------------------------------------
  // Routes
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_route <= '0;
      o_smi_pin_n <= 1'b1;
      o_smi_pin_oe_n <= 1'b1;
      o_group_smi_out_n <= 1'b1;
    end else begin
      o_group_smi_out_n <= ~group_next;
      o_route.to_wake <= group_next & en2_reg[`SER_BIT_WAKE];
      o_route.to_serirq <= group_next & en2_reg[`SER_BIT_SERIRQ];
      // The pin stays driven high while disabled so it never floats low.
      o_smi_pin_n <= ~(group_next & en2_reg[`SER_BIT_PIN]);
      o_smi_pin_oe_n <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt status, write one to clear
  // ----------------------------------------
  logic rise_ev;
  logic fall_ev;
  assign rise_ev = group_next & ~group_reg;
  assign fall_ev = ~group_next & group_reg;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ist_reg <= `SER_RST_VAL;
      imsk_reg <= `SER_RST_VAL;
    end else begin
      if (i_wr && i_addr == `SER_OFS_IMSK) begin
        imsk_reg <= i_wdata;
      end
      // A new event wins over a clear in the same cycle.
      ist_reg[`SER_IST_RISE] <= rise_ev | (ist_reg[`SER_IST_RISE]
        & ~(i_wr && i_addr == `SER_OFS_IST && i_wdata[`SER_IST_RISE]));
      ist_reg[`SER_IST_FALL] <= fall_ev | (ist_reg[`SER_IST_FALL]
        & ~(i_wr && i_addr == `SER_OFS_IST && i_wdata[`SER_IST_FALL]));
      ist_reg[7:2] <= '0;
    end
  end

  assign o_irq = |(ist_reg & imsk_reg);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        `SER_OFS_EN2: o_rdata <= en2_reg;
        `SER_OFS_EN3: o_rdata <= en3_reg;
        `SER_OFS_EN4: o_rdata <= 8'(en4_reg);
        `SER_OFS_IST: o_rdata <= ist_reg;
        `SER_OFS_IMSK: o_rdata <= imsk_reg;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  en_reset_a: assert property (@(posedge i_clock)
    $past(i_sys_rst) |-> en2_reg == 8'h00 && en3_reg == 8'h00)
    else $error("enable not cleared by reset");
  pin_off_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !$past(en2_reg[`SER_BIT_PIN]) |-> o_smi_pin_n)
    else $error("pin asserted while route off");
  wake_route_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_route.to_wake |-> $past(en2_reg[`SER_BIT_WAKE]) && !o_group_smi_out_n)
    else $error("wake route without enable");
  serirq_route_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_route.to_serirq |-> $past(en2_reg[`SER_BIT_SERIRQ]))
    else $error("serirq route without enable");
  per_gate_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (en3_reg == 8'h00 && en4_reg == '0
      && (en2_reg & sync2_reg[7:0] & `SER_EN2_SRC_MASK) != 8'h00)
    |=> group_reg)
    else $error("enabled peripheral source lost");
  rsvd_bit_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (en2_reg == 8'h08 && en3_reg == 8'h08 && en4_reg == '0) |=> !group_reg)
    else $error("reserved bit gated a source");
  gpio_gate_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (en3_reg[0] && sync2_reg[8]) |=> group_reg)
    else $error("gpio 20 source lost");
  gpio_hi_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (en3_reg[7] && sync2_reg[15]) |=> group_reg)
    else $error("gpio 60 source lost");
  extra_gate_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (en4_reg[0] && sync2_reg[16]) |=> group_reg)
    else $error("extra source lost");
  group_or_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (en2_reg == 8'h00 && en3_reg == 8'h00 && en4_reg == '0) |=> !group_reg)
    else $error("group set with all enables off");
  active_high_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (en2_reg[0] && sync2_reg[0]) |=> !o_group_smi_out_n)
    else $error("enabled source did not assert group output");

endmodule

/* tb/ser_host_model.sv */
// Host side model that watches the dedicated SMI pin.
// Assumes a pull-up on the pin while the block does not drive it.
`timescale 1ns/1ns

module ser_host_model (
  input wire logic i_clock, // Bench clock
  input wire logic i_smi_pin_n, // Pin level from the block
  input wire logic i_smi_pin_oe_n, // Low while the block drives
  output logic o_smi_seen // Host sees SMI asserted
);
  // The pull-up wins whenever the block lets go of the wire.
  logic wire_lvl;
  assign wire_lvl = i_smi_pin_oe_n ? 1'b1 : i_smi_pin_n;
  always_ff @(posedge i_clock) begin
    o_smi_seen <= ~wire_lvl;
  end
endmodule

/* tb/ser_smi_route_tb_top.sv */
// Self-checking bench for the SMI gating and routing block.
// Assumes the block, its package and a host model on the pin.
`timescale 1ns/1ns

module ser_smi_route_tb_top;
  import ser_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, pin_n, oe_n, grp_n, irq, seen;
  logic [7:0] addr = 8'h00, wdata = 8'h00, per = 8'h00, gp = 8'h00, ex = 8'h00, rdata;
  ser_route_t route;
  int err_count = 0, n_checks = 0;

  ser_smi_route ser_smi_route_i (.i_clock(clk), .i_sys_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_per_src(per),
    .i_gpio_src(gp), .i_extra_src(ex), .o_route(route), .o_smi_pin_n(pin_n),
    .o_smi_pin_oe_n(oe_n), .o_group_smi_out_n(grp_n), .o_irq(irq));
  ser_host_model ser_host_model_i (.i_clock(clk), .i_smi_pin_n(pin_n),
    .i_smi_pin_oe_n(oe_n), .o_smi_seen(seen));

  initial forever #2 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
    @(posedge clk);
    #1 chk("rdata idle", 8'h00, rdata);
  endtask
  // Sources need two sync stages plus the output flop, so four edges is settled.
  task outs(input logic g, input logic p, input logic [2:0] r, input logic h);
    repeat (4) @(posedge clk);
    #1 chk("group_n", {7'h00, g}, {7'h00, grp_n});
    chk("pin_n", {7'h00, p}, {7'h00, pin_n});
    chk("route", {5'h00, r}, {5'h00, route});
    chk("host", {7'h00, h}, {7'h00, seen});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h18, 8'h00);
    rd_chk(8'h19, 8'h00);
    rd_chk(8'h20, 8'h00);
    chk("oe_n", 8'h00, {7'h00, oe_n});
    wr_reg(8'h17, 8'h5A); wr_reg(8'h18, 8'hA5); wr_reg(8'h19, 8'hC3);
    rd_chk(8'h17, 8'h5A);
    rd_chk(8'h18, 8'hA5);
    rd_chk(8'h19, 8'hC3);
    wr_reg(8'h17, 8'h00); wr_reg(8'h18, 8'h00); wr_reg(8'h19, 8'h00);
    outs(1'b1, 1'b1, 3'h0, 1'b0);
  endtask
  task t_per;
    for (int i = 0; i < 5; i++) begin
      per <= 8'h01 << i;
      wr_reg(8'h17, 8'h80 | (8'h01 << i));
      outs(i == 3, i == 3, 3'h0, i != 3);
      wr_reg(8'h17, 8'h80);
      outs(1'b1, 1'b1, 3'h0, 1'b0);
    end
  endtask
  task t_route;
    per <= 8'h01;
    wr_reg(8'h17, 8'h61);
    outs(1'b0, 1'b1, 3'h6, 1'b0);
    wr_reg(8'h17, 8'h01);
    outs(1'b0, 1'b1, 3'h0, 1'b0);
    wr_reg(8'h17, 8'hE0);
    outs(1'b1, 1'b1, 3'h0, 1'b0);
    per <= 8'h00;
  endtask
  task t_gpio;
    for (int i = 0; i < 8; i++) begin
      gp <= 8'h01 << i;
      wr_reg(8'h18, 8'h01 << i);
      outs(i == 3, i == 3, (i == 3) ? 3'h0 : 3'h6, i != 3);
    end
    wr_reg(8'h18, 8'h00);
    ex <= 8'h01;
    wr_reg(8'h19, 8'h01);
    outs(1'b0, 1'b0, 3'h6, 1'b1);
    wr_reg(8'h19, 8'h02);
    outs(1'b1, 1'b1, 3'h0, 1'b0);
  endtask
  task t_irq;
    wr_reg(8'h1B, 8'h00); wr_reg(8'h1A, 8'h03); wr_reg(8'h19, 8'h01);
    outs(1'b0, 1'b0, 3'h6, 1'b1);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr_reg(8'h1B, 8'h01);
    #1 chk("irq", 8'h01, {7'h00, irq});
    rd_chk(8'h1A, 8'h01);
    wr_reg(8'h1A, 8'h01);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    wr_reg(8'h19, 8'h02);
    rd_chk(8'h1A, 8'h02);
    chk("irq fall masked", 8'h00, {7'h00, irq});
  endtask
  task t_reset;
    wr_reg(8'h17, 8'hFF); wr_reg(8'h18, 8'hFF); wr_reg(8'h19, 8'hFF);
    @(posedge clk); rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h18, 8'h00);
    rd_chk(8'h19, 8'h00);
    rd_chk(8'h1A, 8'h00);
    chk("oe_n after reset", 8'h00, {7'h00, oe_n});
    chk("irq after reset", 8'h00, {7'h00, irq});
    outs(1'b1, 1'b1, 3'h0, 1'b0);
  endtask

  task complete_run;
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_per;
    t_route;
    t_gpio;
    t_irq;
    t_reset;
    complete_run;
  end
endmodule
